// File: rtl/ecp_defs.svh
/*
 Register offsets, field positions, reset values and mode codes of the
 parallel port FIFO transfer block. Assumes an 11-bit register address space.
*/
`ifndef ECP_DEFS_SVH
`define ECP_DEFS_SVH

`define ADDR_W 11
`define OFF_DATA 11'h000
`define OFF_DSR 11'h001
`define OFF_DCR 11'h002
`define OFF_DFIFO 11'h400
`define OFF_ECR 11'h402
`define OFF_CFG5 11'h405
`define OFF_FDD 11'h406

`define DCR_DIR 5
`define ECR_MODE_HI 7
`define ECR_MODE_LO 5
`define ECR_DMA_ENABLE_BIT 3
`define ECR_SIF 2
`define ECR_FULL 1
`define ECR_EMPTY 0
`define FDD_SINGLE 0
`define FDD_DUAL 1

`define MODE_STD 3'h0
`define MODE_PS2 3'h1
`define MODE_COMPAT_DATA_FIFO 3'h2
`define MODE_ECP 3'h3

`define FIFO_DEPTH 16
`define FIFO_W 9
`define CNT_W 5
`define THR_W 4
`define THR_RST 4'h8

`endif

// File: rtl/ecp_pkg.sv
/*
 Types of the parallel port FIFO transfer block: link state and the
 packed state record of the top module. Assumes ecp_defs.svh on the include path.
*/
`include "ecp_defs.svh"

package ecp_pkg;

	typedef enum logic [4:0] {
		ST_IDLE    = 5'b00001,
		ST_FWD_STB = 5'b00010,
		ST_FWD_REL = 5'b00100,
		ST_REV_REQ = 5'b01000,
		ST_REV_REL = 5'b10000
	} link_st_t;

	typedef struct packed {
		logic [2:0] mode;
		logic dir;
		logic dma_en;
		logic sif;
		logic [`THR_W-1:0] thr;
		logic ext1;
		logic ext2;
		logic [7:0] pd_out;
		logic cmd;
		logic strobe_n;
		logic host_ack;
		link_st_t link;
		logic [7:0] rdata;
		logic [7:0] dma_rdata;
	} port_st_t;

endpackage

// File: rtl/pin_sync.sv
/*
 Three-flop input synchroniser with an agreement filter per bit.
 Assumes the inputs are asynchronous to clk_i.
*/
`timescale 1ns/1ns
`default_nettype none

module pin_sync #(
	parameter int W = 8
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic resetn_i,
	// Pins and filtered levels
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] q;
	} sync_st_t;

	sync_st_t st_r, st_nxt;

	always_comb begin
		st_nxt = st_r;
		st_nxt.s1 = d_i;
		st_nxt.s2 = st_r.s1;
		st_nxt.s3 = st_r.s2;
		// A bit only moves once the last two stages agree
		for (int i = 0; i < W; i++) begin
			if (st_r.s2[i] == st_r.s3[i]) begin
				st_nxt.q[i] = st_r.s3[i];
			end
		end
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign q_o = st_r.q;
endmodule // pin_sync

`default_nettype wire

// File: rtl/byte_fifo.sv
/*
 Synchronous FIFO with valid/ready on both sides and a clear input.
 Assumes a push while full is refused through in_ready_o.
*/
`timescale 1ns/1ns
`default_nettype none

module byte_fifo #(
	parameter int W = 9,
	parameter int DEPTH = 16
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic resetn_i,
	input wire logic clear_i,
	// Fill side
	input wire logic in_valid_i,
	input wire logic [W-1:0] in_data_i,
	output logic in_ready_o,
	// Drain side
	output logic out_valid_o,
	output logic [W-1:0] out_data_o,
	input wire logic out_ready_i,
	output logic [$clog2(DEPTH):0] count_o
);
	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0] cnt;
	} fifo_st_t;

	fifo_st_t st_r, st_nxt;
	logic push, pop;

	assign in_ready_o = (st_r.cnt != (AW+1)'(DEPTH)) && !clear_i;
	assign out_valid_o = (st_r.cnt != '0) && !clear_i;
	assign out_data_o = st_r.mem[st_r.rp];
	assign count_o = st_r.cnt;
	assign push = in_valid_i && in_ready_o;
	assign pop = out_valid_o && out_ready_i;

	always_comb begin
		st_nxt = st_r;
		if (clear_i) begin
			st_nxt.wp = '0;
			st_nxt.rp = '0;
			st_nxt.cnt = '0;
		end else begin
			if (push) begin
				st_nxt.mem[st_r.wp] = in_data_i;
				st_nxt.wp = st_r.wp + AW'(1);
			end
			if (pop) begin
				st_nxt.rp = st_r.rp + AW'(1);
			end
			st_nxt.cnt = st_r.cnt + (AW+1)'(push) - (AW+1)'(pop);
		end
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end
endmodule // byte_fifo

`default_nettype wire

// File: rtl/ecp_port.sv
/*
 Parallel port FIFO transfer engine with floppy extension pin muxing.
 Assumes a plain register port, a PC style DMA request/acknowledge pair
 and printer pins that are asynchronous to clk_i.
*/
// What this block does
// - No compression in hardware; counts and bytes are forwarded as given.
// - FIFO service threshold comes from configuration register 5.
// - Transfers go by DMA or programmed I/O according to selected mode.
// - Shared FIFO is active only in parallel FIFO mode or ECP mode.
// - After reset the FIFO stays disabled until a FIFO mode is chosen.
// - DMA moves only data, test or compatibility FIFO bytes, never addresses; in reverse DMA drains command bytes as well.
// - DMA service is requested on the DMA request pin, host acknowledges.
// - DMA fills FIFO forward or drains it in reverse by direction and mode.
// - Terminal count raises interrupt and service flag, which stops DMA requests.
// - Data and test FIFO answer at 400H, address FIFO writes at 000H.
// - In programmed I/O the interrupt pin requests FIFO filling or emptying.
// - Single external floppy mode forces drive B motor and select inactive.
// - Dual external floppy mode forces drives A and B outputs inactive.
// - Floppy inputs are ORed with parallel data lines 4 down to 0.
// - All FIFO views share one sixteen byte FIFO.
// - Outside modes 000/001 only 000/001 may be chosen; direction only in 001.
// - Forward host acknowledge is high for data bytes, low for commands.
`timescale 1ns/1ns
`default_nettype none
`include "ecp_defs.svh"

module ecp_port
	import ecp_pkg::*;
#(
	parameter int DEPTH = `FIFO_DEPTH
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic resetn_i,
	// Register port
	input wire logic [`ADDR_W-1:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [7:0] reg_rdata_o,
	// DMA and interrupt
	output logic port_dma_request_o,
	input wire logic dma_ack_i,
	input wire logic dma_tc_i,
	input wire logic [7:0] dma_wdata_i,
	output logic [7:0] dma_rdata_o,
	output logic irq_o,
	// Parallel pins
	input wire logic [7:0] pd_i,
	output logic [7:0] pd_o,
	output logic pd_oe_o,
	output logic strobe_n_o,
	output logic host_ack_o,
	output logic reverse_req_n_o,
	input wire logic busy_i,
	input wire logic ack_n_i,
	// Floppy controller side
	input wire logic fdc_drive_a_motor_n_i,
	input wire logic fdc_drive_a_select_n_i,
	input wire logic fdc_drive_b_motor_n_i,
	input wire logic fdc_drive_b_select_n_i,
	output logic fdc_disk_change_n_o,
	output logic fdc_read_data_n_o,
	output logic fdc_write_protect_n_o,
	output logic fdc_track_zero_n_o,
	output logic fdc_index_n_o,
	// Floppy drive pins
	output logic drive_a_motor_n_o,
	output logic drive_a_select_n_o,
	output logic drive_b_motor_n_o,
	output logic drive_b_select_n_o,
	input wire logic disk_change_n_i,
	input wire logic read_data_n_i,
	input wire logic write_protect_n_i,
	input wire logic track_zero_n_i,
	input wire logic index_n_i
);
	function automatic logic fifo_mode(input logic [2:0] m);
		return (m == `MODE_COMPAT_DATA_FIFO) || (m == `MODE_ECP);
	endfunction

	function automatic logic pio_mode(input logic [2:0] m);
		return (m == `MODE_STD) || (m == `MODE_PS2);
	endfunction

	port_st_t st_r, st_nxt;

	logic [14:0] pins_s;
	logic [7:0] pd_s;
	logic busy_s, ack_n_s;
	logic dc_s, rd_s, wp_s, tz_s, ix_s;
	logic fifo_on, rev, floppy, pio_need;
	logic push, pop, link_pop, bus_pop, dma_pop;
	logic [`FIFO_W-1:0] push_data;
	logic in_ready, out_valid;
	logic [`FIFO_W-1:0] out_data;
	localparam int CW = $clog2(DEPTH) + 1;
	logic [CW-1:0] count;
	logic [CW-1:0] free;
	logic wr_ecr;

	pin_sync #(
		.W(15)
	) u_sync (
		.clk_i(clk_i),
		.resetn_i(resetn_i),
		// Active-low pins cross inverted, so a cleared synchroniser reads as idle
		.d_i({busy_i, ~ack_n_i, ~disk_change_n_i, ~read_data_n_i, ~write_protect_n_i,
			~track_zero_n_i, ~index_n_i, pd_i}),
		.q_o(pins_s)
	);

	assign {busy_s, ack_n_s, dc_s, rd_s, wp_s, tz_s, ix_s, pd_s} = pins_s ^ 15'h3F00;

	// One store serves every FIFO view; it is flushed while no FIFO mode is on
	byte_fifo #(
		.W(`FIFO_W),
		.DEPTH(DEPTH)
	) u_fifo (
		.clk_i(clk_i),
		.resetn_i(resetn_i),
		.clear_i(!fifo_on),
		.in_valid_i(push),
		.in_data_i(push_data),
		.in_ready_o(in_ready),
		.out_valid_o(out_valid),
		.out_data_o(out_data),
		.out_ready_i(pop),
		.count_o(count)
	);

	assign fifo_on = fifo_mode(st_r.mode);
	assign rev = st_r.dir && (st_r.mode == `MODE_ECP);
	assign floppy = st_r.ext1 || st_r.ext2;
	assign free = CW'(DEPTH) - count;
	assign wr_ecr = reg_wr_i && (reg_addr_i == `OFF_ECR);
	// Programmed I/O wants service once the threshold of room or bytes is met
	assign pio_need = rev ? (count >= CW'(st_r.thr)) : (free >= CW'(st_r.thr));
	assign pop = link_pop || bus_pop || dma_pop;

	always_comb begin
		st_nxt = st_r;
		push = 1'b0;
		push_data = '0;
		link_pop = 1'b0;
		bus_pop = 1'b0;
		dma_pop = 1'b0;
		st_nxt.rdata = 8'h00;

		if (reg_wr_i) begin
			case (reg_addr_i)
				`OFF_DATA: begin
					if (st_r.mode == `MODE_ECP && !rev) begin
						push = 1'b1;
						push_data = {1'b1, reg_wdata_i};
					end else if (!fifo_on) begin
						st_nxt.pd_out = reg_wdata_i;
					end
				end
				`OFF_DCR: begin
					if (st_r.mode == `MODE_PS2) begin
						st_nxt.dir = reg_wdata_i[`DCR_DIR];
					end
				end
				`OFF_DFIFO: begin
					if (fifo_on && !rev) begin
						push = 1'b1;
						push_data = {1'b0, reg_wdata_i};
					end
				end
				`OFF_ECR: begin
					if (pio_mode(st_r.mode) || pio_mode(reg_wdata_i[`ECR_MODE_HI:`ECR_MODE_LO])) begin
						st_nxt.mode = reg_wdata_i[`ECR_MODE_HI:`ECR_MODE_LO];
					end
					st_nxt.dma_en = reg_wdata_i[`ECR_DMA_ENABLE_BIT];
					st_nxt.sif = reg_wdata_i[`ECR_SIF];
				end
				`OFF_CFG5: st_nxt.thr = reg_wdata_i[`THR_W-1:0];
				`OFF_FDD: begin
					st_nxt.ext1 = reg_wdata_i[`FDD_SINGLE];
					st_nxt.ext2 = reg_wdata_i[`FDD_DUAL];
				end
				default: ;
			endcase
		end

		// DMA bytes only ever land as plain data, never as address entries
		if (dma_ack_i && fifo_on) begin
			if (!rev && !push) begin
				push = 1'b1;
				push_data = {1'b0, dma_wdata_i};
			end else if (rev && out_valid) begin
				st_nxt.dma_rdata = out_data[7:0];
				dma_pop = 1'b1;
			end
		end

		// Hardware sets win over a software clear in the same cycle
		if (dma_ack_i && dma_tc_i) begin
			st_nxt.sif = 1'b1;
		end
		if (fifo_on && !st_r.dma_en && pio_need) begin
			st_nxt.sif = 1'b1;
		end

		if (reg_rd_i) begin
			case (reg_addr_i)
				`OFF_DATA: st_nxt.rdata = st_r.dir ? pd_s : st_r.pd_out;
				`OFF_DSR: st_nxt.rdata = {!busy_s, ack_n_s, 3'h0, 3'h7};
				`OFF_DCR: st_nxt.rdata = {2'h3, st_r.dir, 5'h00};
				`OFF_DFIFO: begin
					if (rev && out_valid) begin
						st_nxt.rdata = out_data[7:0];
						bus_pop = 1'b1;
					end
				end
				`OFF_ECR: st_nxt.rdata = {st_r.mode, 1'b0, st_r.dma_en, st_r.sif,
					!in_ready && fifo_on, !out_valid};
				`OFF_CFG5: st_nxt.rdata = {4'h0, st_r.thr};
				`OFF_FDD: st_nxt.rdata = {6'h00, st_r.ext2, st_r.ext1};
				default: st_nxt.rdata = 8'h00;
			endcase
		end

		unique case (st_r.link)
			ST_IDLE: begin
				if (fifo_on && !rev && out_valid) begin
					// Bytes go out exactly as stored, command flag included
					st_nxt.pd_out = out_data[7:0];
					st_nxt.cmd = out_data[8];
					st_nxt.host_ack = !out_data[8];
					st_nxt.strobe_n = 1'b0;
					link_pop = 1'b1;
					st_nxt.link = ST_FWD_STB;
				end else if (rev && in_ready) begin
					st_nxt.host_ack = 1'b0;
					st_nxt.link = ST_REV_REQ;
				end
			end
			ST_FWD_STB: begin
				if (busy_s) begin
					st_nxt.strobe_n = 1'b1;
					st_nxt.link = ST_FWD_REL;
				end
			end
			ST_FWD_REL: begin
				if (!busy_s) begin
					st_nxt.link = ST_IDLE;
				end
			end
			ST_REV_REQ: begin
				// Only the link fills the FIFO in reverse, so room is still there
				if (!ack_n_s) begin
					push = 1'b1;
					push_data = {!busy_s, pd_s};
					st_nxt.host_ack = 1'b1;
					st_nxt.link = ST_REV_REL;
				end
			end
			ST_REV_REL: begin
				if (ack_n_s) begin
					st_nxt.link = ST_IDLE;
				end
			end
		endcase

		if (!fifo_on) begin
			st_nxt.link = ST_IDLE;
			st_nxt.strobe_n = 1'b1;
			st_nxt.host_ack = 1'b1;
		end
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			st_r <= '{mode: `MODE_STD, thr: `THR_RST, strobe_n: 1'b1, host_ack: 1'b1,
				link: ST_IDLE, default: '0};
		end else begin
			st_r <= st_nxt;
		end
	end

	// Service flag blocks requests until software clears it
	assign port_dma_request_o = fifo_on && st_r.dma_en && !st_r.sif &&
		(rev ? out_valid : in_ready);
	assign irq_o = st_r.sif;
	assign reg_rdata_o = st_r.rdata;
	assign dma_rdata_o = st_r.dma_rdata;

	assign pd_o = st_r.pd_out;
	assign pd_oe_o = !st_r.dir && !floppy;
	assign strobe_n_o = st_r.strobe_n;
	assign host_ack_o = st_r.host_ack;
	assign reverse_req_n_o = !st_r.dir;

	assign drive_a_motor_n_o = st_r.ext2 ? 1'b1 : fdc_drive_a_motor_n_i;
	assign drive_a_select_n_o = st_r.ext2 ? 1'b1 : fdc_drive_a_select_n_i;
	assign drive_b_motor_n_o = floppy ? 1'b1 : fdc_drive_b_motor_n_i;
	assign drive_b_select_n_o = floppy ? 1'b1 : fdc_drive_b_select_n_i;
	// Data lines only join in while a floppy extension mode owns the connector
	assign fdc_disk_change_n_o = dc_s | (floppy & pd_s[4]);
	assign fdc_read_data_n_o = rd_s | (floppy & pd_s[3]);
	assign fdc_write_protect_n_o = wp_s | (floppy & pd_s[2]);
	assign fdc_track_zero_n_o = tz_s | (floppy & pd_s[1]);
	assign fdc_index_n_o = ix_s | (floppy & pd_s[0]);

	a_mode_lock: assert property (@(posedge clk_i) disable iff (!resetn_i)
		(wr_ecr && !pio_mode(st_r.mode) && !pio_mode(reg_wdata_i[7:5])) |=> $stable(st_r.mode))
		else $error("mode left a FIFO mode for another non-basic mode");

	a_dir_lock: assert property (@(posedge clk_i) disable iff (!resetn_i)
		!$stable(st_r.dir) |-> ($past(st_r.mode) == `MODE_PS2))
		else $error("direction changed outside mode 001");

	a_fifo_flush: assert property (@(posedge clk_i) disable iff (!resetn_i)
		!fifo_on |=> (count == '0) || fifo_on)
		else $error("FIFO holds data outside FIFO modes");

	a_tc_service: assert property (@(posedge clk_i) disable iff (!resetn_i)
		(dma_ack_i && dma_tc_i) |=> (st_r.sif && irq_o && !port_dma_request_o))
		else $error("terminal count did not raise service flag");

	a_dma_no_addr: assert property (@(posedge clk_i) disable iff (!resetn_i)
		(dma_ack_i && !rev && fifo_on && !reg_wr_i) |-> (push && !push_data[8]))
		else $error("DMA byte not pushed as plain data");

	a_pio_service: assert property (@(posedge clk_i) disable iff (!resetn_i)
		(fifo_on && !st_r.dma_en && pio_need && !wr_ecr) |=> irq_o)
		else $error("programmed I/O service not requested");

	a_floppy_b_off: assert property (@(posedge clk_i) disable iff (!resetn_i)
		st_r.ext1 |-> (drive_b_motor_n_o && drive_b_select_n_o))
		else $error("drive B outputs active in single floppy mode");

	a_floppy_a_off: assert property (@(posedge clk_i) disable iff (!resetn_i)
		st_r.ext2 |-> (drive_a_motor_n_o && drive_a_select_n_o && drive_b_motor_n_o))
		else $error("internal drive outputs active in dual floppy mode");

	a_floppy_or: assert property (@(posedge clk_i) disable iff (!resetn_i)
		floppy |-> (fdc_index_n_o == (ix_s | pd_s[0])) && (fdc_disk_change_n_o == (dc_s | pd_s[4])))
		else $error("floppy inputs not ORed with data lines");

	a_host_ack_cmd: assert property (@(posedge clk_i) disable iff (!resetn_i)
		(st_r.link == ST_FWD_STB) |-> (!strobe_n_o && (host_ack_o == !st_r.cmd)))
		else $error("host acknowledge does not match byte kind");

	a_strobe_hold: assert property (@(posedge clk_i) disable iff (!resetn_i)
		($rose(st_r.link == ST_FWD_STB) && !busy_s) |=> (!strobe_n_o && $stable(pd_o)))
		else $error("forward byte changed while strobe active");
endmodule // ecp_port

`default_nettype wire

// File: tb/printer_peer.sv
/*
 Printer-side peer for the ECP port bench: busy handshake forward, nAck pulses reverse.
 Assumes the port's outputs change just after rising edges of clk_i.
*/
`timescale 1ns/1ns
`default_nettype none

module printer_peer (
	// Clock, reset, pacing
	input wire logic clk_i,
	input wire logic resetn_i,
	input wire logic slow_i,
	// Host side of the link
	input wire logic strobe_n_i,
	input wire logic host_ack_i,
	input wire logic [7:0] pd_out_i,
	// Peer drive
	output logic busy_o,
	output logic ack_n_o,
	output logic [7:0] pd_line_o,
	// Floppy drive levels on the low data lines
	input wire logic fdd_en_i,
	input wire logic [4:0] fdd_pd_i
);
	logic [8:0] rx_q[$];
	logic [8:0] tx_q[$];
	logic drv_r;
	int st_r;
	int wait_r;

	always @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			busy_o <= 1'b0;
			ack_n_o <= 1'b1;
			drv_r <= 1'b0;
			st_r <= 0;
			wait_r <= 0;
			pd_line_o <= 8'h00;
		end else begin
			// Released lines toggle each cycle, except the low five, which follow fdd_pd_i while fdd_en_i is set
			if (!drv_r)
				pd_line_o <= fdd_en_i ? {~pd_line_o[7:5], fdd_pd_i} : ~pd_line_o;
			if (wait_r > 0)
				wait_r <= wait_r - 1;
			else case (st_r)
			0: if (!strobe_n_i) begin
				rx_q.push_back({~host_ack_i, pd_out_i});
				busy_o <= 1'b1;
				st_r <= 1;
				wait_r <= slow_i ? 8 : 0;
			end else if (!host_ack_i && tx_q.size() > 0) begin
				pd_line_o <= tx_q[0][7:0];
				busy_o <= ~tx_q[0][8];
				drv_r <= 1'b1;
				st_r <= 2;
			end
			1: if (strobe_n_i) begin
				busy_o <= 1'b0;
				st_r <= 0;
			end
			2: begin
				ack_n_o <= 1'b0;
				st_r <= 3;
			end
			3: if (host_ack_i) begin
				ack_n_o <= 1'b1;
				st_r <= 4;
			end
			default: begin
				drv_r <= 1'b0;
				busy_o <= 1'b0;
				void'(tx_q.pop_front());
				st_r <= 0;
			end
			endcase
		end
	end
endmodule // printer_peer

`default_nettype wire

// File: tb/ecp_fifo_transfer_and_floppy_extension_test.sv
/*
 Self-checking bench of ecp_port with a printer peer and queue models.
 Assumes ecp_defs.svh on the include path.
*/
`timescale 1ns/1ns
`default_nettype none
`include "ecp_defs.svh"

module ecp_fifo_transfer_and_floppy_extension_test;
	import ecp_pkg::*;
	logic clk_i, resetn_i, reg_wr_i, reg_rd_i, dma_ack_i, dma_tc_i, slow, fdd_en;
	logic [`ADDR_W-1:0] reg_addr_i;
	logic [7:0] reg_wdata_i, dma_wdata_i, d, pd_o, pd_line, reg_rdata_o, dma_rdata_o;
	logic [3:0] fdc_in;
	logic [4:0] pins, fdd_pd;
	wire logic [4:0] fdc_out;
	wire logic [3:0] drv_out;
	logic dreq, irq, pd_oe, stb_n, hack, rrq_n, busy, ack_n;
	logic [31:0] seed;
	logic [8:0] exp_q[$];
	logic [7:0] rexp_q[$];
	int fail_count, n_checks, cyc, k, i, sent, saw_low;

	ecp_port i_ecp_port (.clk_i(clk_i), .resetn_i(resetn_i), .reg_addr_i(reg_addr_i),
		.reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
		.reg_rdata_o(reg_rdata_o), .port_dma_request_o(dreq), .dma_ack_i(dma_ack_i),
		.dma_tc_i(dma_tc_i), .dma_wdata_i(dma_wdata_i), .dma_rdata_o(dma_rdata_o),
		.irq_o(irq), .pd_i(pd_oe ? pd_o : pd_line), .pd_o(pd_o), .pd_oe_o(pd_oe),
		.strobe_n_o(stb_n), .host_ack_o(hack), .reverse_req_n_o(rrq_n), .busy_i(busy),
		.ack_n_i(ack_n), .fdc_drive_a_motor_n_i(fdc_in[3]), .fdc_drive_a_select_n_i(fdc_in[2]),
		.fdc_drive_b_motor_n_i(fdc_in[1]), .fdc_drive_b_select_n_i(fdc_in[0]),
		.fdc_disk_change_n_o(fdc_out[4]), .fdc_read_data_n_o(fdc_out[3]),
		.fdc_write_protect_n_o(fdc_out[2]), .fdc_track_zero_n_o(fdc_out[1]),
		.fdc_index_n_o(fdc_out[0]), .drive_a_motor_n_o(drv_out[3]),
		.drive_a_select_n_o(drv_out[2]), .drive_b_motor_n_o(drv_out[1]),
		.drive_b_select_n_o(drv_out[0]), .disk_change_n_i(pins[4]), .read_data_n_i(pins[3]),
		.write_protect_n_i(pins[2]), .track_zero_n_i(pins[1]), .index_n_i(pins[0]));

	printer_peer i_printer_peer (.clk_i(clk_i), .resetn_i(resetn_i), .slow_i(slow),
		.strobe_n_i(stb_n), .host_ack_i(hack), .pd_out_i(pd_o), .busy_o(busy),
		.ack_n_o(ack_n), .pd_line_o(pd_line), .fdd_en_i(fdd_en), .fdd_pd_i(fdd_pd));

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	task automatic check(input logic [31:0] seen, input logic [31:0] expv);
		n_checks++;
		if (seen !== expv) begin
			fail_count++;
			$display("Error at %0t: seen %h expected %h", $time, seen, expv);
		end
	endtask

	task automatic wr(input logic [`ADDR_W-1:0] a, input logic [7:0] v);
		@(posedge clk_i);
		reg_wr_i <= 1'b1;
		reg_addr_i <= a;
		reg_wdata_i <= v;
		@(posedge clk_i);
		reg_wr_i <= 1'b0;
	endtask

	task automatic rd(input logic [`ADDR_W-1:0] a, output logic [7:0] v);
		@(posedge clk_i);
		reg_rd_i <= 1'b1;
		reg_addr_i <= a;
		@(posedge clk_i);
		reg_rd_i <= 1'b0;
		#1;
		v = reg_rdata_o;
	endtask

	// Waits for the peer to hold n bytes, then compares them in order
	task automatic drain_rx(input int n);
		for (k = 0; k < 3000 && i_printer_peer.rx_q.size() < n; k++)
			@(posedge clk_i);
		#1;
		check(i_printer_peer.rx_q.size(), n);
		while (i_printer_peer.rx_q.size() > 0 && exp_q.size() > 0)
			check(i_printer_peer.rx_q.pop_front(), exp_q.pop_front());
	endtask

	task automatic end_of_test;
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	initial begin
		clk_i = 1'b0;
		forever #2 clk_i = ~clk_i;
	end

	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 20000) begin
			fail_count++;
			end_of_test();
		end
	end

	initial begin
		{resetn_i, reg_wr_i, reg_rd_i, dma_ack_i, dma_tc_i, slow, fdd_en} = '0;
		{reg_addr_i, reg_wdata_i, dma_wdata_i, fdc_in, pins, fdd_pd} = '0;
		seed = 32'hBC1FBF17;
		repeat (5) @(posedge clk_i);
		resetn_i <= 1'b1;
		@(posedge clk_i);
		#1;
		check({stb_n, irq, dreq, rrq_n, pd_oe}, 5'h13);
		rd(`OFF_ECR, d);
		check(d & 8'hEC, 8'h00);
		rd(`OFF_CFG5, d);
		check(d[3:0], `THR_RST);
		rd(11'h123, d);
		check(d, 8'h00);
		wr(`OFF_DFIFO, 8'hAA);
		repeat (20) @(posedge clk_i);
		check(i_printer_peer.rx_q.size(), 0);
		// Command then data pairs, sent by programmed I/O in ECP mode
		wr(`OFF_ECR, 8'h60);
		wr(`OFF_DCR, 8'h20);
		for (i = 0; i < 3; i++) begin
			seed = lfsr(seed);
			wr(`OFF_DATA, {1'b0, seed[6:0]});
			wr(`OFF_DFIFO, seed[15:8]);
			exp_q.push_back({2'b10, seed[6:0]});
			exp_q.push_back({1'b0, seed[15:8]});
		end
		drain_rx(6);
		check({rrq_n, pd_oe}, 2'b11);
		check(irq, 1'b1);
		wr(`OFF_ECR, 8'h40);
		rd(`OFF_ECR, d);
		check(d[7:5], `MODE_ECP);
		// DMA forward with a slow peer; 28 bytes outrun it, so the FIFO fills
		wr(`OFF_ECR, 8'h00);
		wr(`OFF_ECR, 8'h48);
		slow <= 1'b1;
		sent = 0;
		saw_low = 0;
		for (k = 0; k < 4000 && sent < 28; k++) begin
			@(posedge clk_i);
			#1;
			check(irq, 1'b0);
			if (dreq === 1'b1) begin
				seed = lfsr(seed);
				@(posedge clk_i);
				dma_ack_i <= 1'b1;
				dma_tc_i <= (sent == 27);
				dma_wdata_i <= seed[7:0];
				exp_q.push_back({1'b0, seed[7:0]});
				sent++;
				@(posedge clk_i);
				dma_ack_i <= 1'b0;
				dma_tc_i <= 1'b0;
			end else
				saw_low = 1;
		end
		#1;
		check({irq, dreq}, 2'b10);
		check(saw_low, 1);
		drain_rx(28);
		// DMA reverse: direction set in mode 001, peer sends bytes
		slow <= 1'b0;
		wr(`OFF_ECR, 8'h00);
		wr(`OFF_ECR, 8'h20);
		wr(`OFF_DCR, 8'h20);
		wr(`OFF_ECR, 8'h68);
		for (i = 0; i < 4; i++) begin
			seed = lfsr(seed);
			i_printer_peer.tx_q.push_back(seed[8:0]);
			rexp_q.push_back(seed[7:0]);
		end
		for (k = 0; k < 3000 && rexp_q.size() > 0; k++) begin
			@(posedge clk_i);
			#1;
			if (dreq === 1'b1) begin
				@(posedge clk_i);
				dma_ack_i <= 1'b1;
				@(posedge clk_i);
				dma_ack_i <= 1'b0;
				#1;
				check(dma_rdata_o, rexp_q.pop_front());
			end
		end
		check(rexp_q.size(), 0);
		// One more byte, taken by programmed I/O at the data FIFO offset
		seed = lfsr(seed);
		i_printer_peer.tx_q.push_back({1'b0, seed[7:0]});
		repeat (30) @(posedge clk_i);
		rd(`OFF_DFIFO, d);
		check(d, seed[7:0]);
		check({rrq_n, pd_oe}, 2'b00);
		// Floppy extension: off, single, dual
		wr(`OFF_ECR, 8'h00);
		for (i = 0; i < 3; i++) begin
			seed = lfsr(seed);
			wr(`OFF_FDD, i[7:0]);
			fdd_en <= (i != 0);
			fdd_pd <= seed[4:0];
			pins <= seed[9:5];
			fdc_in <= seed[13:10];
			repeat (6) @(posedge clk_i);
			#1;
			check(fdc_out, (i != 0) ? (seed[9:5] | seed[4:0]) : seed[9:5]);
			check(drv_out[3:2], (i == 2) ? 2'b11 : seed[13:12]);
			check(drv_out[1:0], (i != 0) ? 2'b11 : seed[11:10]);
		end
		end_of_test();
	end
endmodule // ecp_fifo_transfer_and_floppy_extension_test

`default_nettype wire
